//--- rac_regs.sv
// Register access block: AXI4-Lite slave over the eleven-bit register space
`timescale 1ns/1ps
module rac_regs #(
  parameter int unsigned PORT_COUNT = 4,
  parameter logic [15:0] ID_VALUE = 16'h5A01  // Identity value, arbitrary
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  // Register bus
  input wire rac_pkg::rac_axi_req_t I_AXI_REQ,
  output rac_pkg::rac_axi_rsp_t O_AXI_RSP,
  // Data path events
  input wire logic I_DATAPATH_RESET_N,
  input wire rac_pkg::rac_ev_t [rac_pkg::NUM_PORTS-1:0] I_EVENT,
  input wire logic [rac_pkg::NUM_PORTS-1:0] I_COUNT_EVENT,
  // Status outputs
  output logic O_COUNTER_SNAPSHOT_DONE,
  output logic O_ZERO_COUNT_N,
  output logic O_INT_N
);
  import rac_pkg::*;

  logic rst_meta_reg;
  logic rst_sync_reg;
  rac_state_t state_reg;
  rac_state_t state_next;
  logic [10:0] rd_idx;
  logic [10:0] wr_idx;
  logic [8:0] rd_even;
  logic [8:0] wr_even;
  logic rd_take;
  logic wr_do;
  logic rd_map;
  logic wr_map;
  logic snap_go;

  // Checks below run on the block clock and pause during reset
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!rst_sync_reg);

  // Fold the top index bit away on variants that leave it unused
  function automatic logic [10:0] fold_idx(input logic [AXI_AW-1:0] addr);
    logic [10:0] idx;
    idx = addr[12:2];
    if (PORT_COUNT <= 2) begin
      idx[10] = 1'b0;
    end
    return idx;
  endfunction

  // Whether an index lies in space that answers the bus
  function automatic logic idx_mapped(input logic [10:0] idx);
    logic [1:0] rgn;
    logic [8:0] ofs;
    logic ok;
    rgn = idx[10:9];
    ofs = idx[8:0];
    if (ofs >= PORT_FIRST) begin
      ok = (32'(rgn) < PORT_COUNT);
    end else if (rgn == 2'h0) begin
      ok = (ofs <= GL_LAST) || (ofs > GL_UNUSED_LAST);
    end else begin
      ok = (rgn != 2'h3);
    end
    return ok;
  endfunction

  // Sixteen-bit value of the register pair holding an index
  function automatic logic [15:0] reg_value(input rac_state_t s, input logic [10:0] idx);
    logic [15:0] val;
    logic [8:0] even;
    int unsigned p;
    val = 16'h0000;
    even = {idx[8:1], 1'b0};
    p = 32'(idx[10:9]);
    if (even < PORT_FIRST) begin
      if (p == 0) begin
        case (even)
          OFS_GL_ID: val = ID_VALUE;
          OFS_GL_CTRL: val = s.gl_ctrl;
          OFS_GL_STAT: val = {15'h0000, s.done};
          default: val = 16'h0000;
        endcase
      end
    end else if (p < PORT_COUNT) begin
      case (even)
        OFS_P_CTRL: val = s.ports[p].ctrl;
        OFS_P_STAT: val = {12'h000, I_EVENT[p] & (s.ports[p].mode_app ? ~RSV_MASK : 4'hF)};
        OFS_P_LATCH: val = {12'h000, s.ports[p].latch};
        OFS_P_IE: val = s.ports[p].ie;
        OFS_P_CNT: val = s.ports[p].cnt_reg;
        default: val = 16'h0000;
      endcase
    end
    return val;
  endfunction

  // Bus request decode
  assign rd_idx = fold_idx(I_AXI_REQ.araddr);
  assign wr_idx = state_reg.w_idx;
  assign rd_even = {rd_idx[8:1], 1'b0};
  assign wr_even = {wr_idx[8:1], 1'b0};
  assign rd_take = I_AXI_REQ.arvalid && state_reg.rsp.arready;
  assign wr_do = state_reg.aw_have && state_reg.w_have && !state_reg.rsp.bvalid;
  assign rd_map = idx_mapped(rd_idx);
  assign wr_map = idx_mapped(wr_idx);
  // Strobe edges count only outside data path reset
  assign snap_go = state_reg.gl_ctrl[GC_SNAP_BIT] && !state_reg.snap_prev && I_DATAPATH_RESET_N
                   && (state_reg.snap_st == SNAP_IDLE);

  // Next-state logic for the whole block
  always_comb begin
    logic bus16;
    logic lcm;
    logic hit;
    logic inc;
    logic any_int;
    logic [15:0] wd;
    logic [15:0] wm;
    logic [15:0] rv;
    logic [EV_W-1:0] rise;
    logic [EV_W-1:0] fall;
    logic [EV_W-1:0] set;
    logic [EV_W-1:0] clr;
    bus16 = state_reg.gl_ctrl[GC_BUS16_BIT];
    lcm = state_reg.gl_ctrl[GC_LCM_BIT];
    hit = 1'b0;
    inc = 1'b0;
    any_int = 1'b0;
    wd = 16'h0000;
    wm = 16'h0000;
    rv = 16'h0000;
    rise = '0;
    fall = '0;
    set = '0;
    clr = '0;
    state_next = state_reg;

    // Write address and data are taken independently
    if (I_AXI_REQ.awvalid && state_reg.rsp.awready) begin
      state_next.rsp.awready = 1'b0;
      state_next.aw_have = 1'b1;
      state_next.w_idx = fold_idx(I_AXI_REQ.awaddr);
    end
    if (I_AXI_REQ.wvalid && state_reg.rsp.wready) begin
      state_next.rsp.wready = 1'b0;
      state_next.w_have = 1'b1;
      state_next.wdata = I_AXI_REQ.wdata;
      state_next.wstrb = I_AXI_REQ.wstrb;
    end
    // Both halves held: perform the write and answer
    if (wr_do) begin
      state_next.aw_have = 1'b0;
      state_next.w_have = 1'b0;
      state_next.rsp.bvalid = 1'b1;
      state_next.rsp.bresp = wr_map ? RESP_OKAY : RESP_DECERR;
    end
    if (state_reg.rsp.bvalid && I_AXI_REQ.bready) begin
      state_next.rsp.bvalid = 1'b0;
      state_next.rsp.awready = 1'b1;
      state_next.rsp.wready = 1'b1;
    end

    // Read answer is registered at the taking edge
    if (rd_take) begin
      rv = reg_value(state_reg, rd_idx);
      state_next.rsp.arready = 1'b0;
      state_next.rsp.rvalid = 1'b1;
      state_next.rsp.rresp = rd_map ? RESP_OKAY : RESP_DECERR;
      if (bus16) begin
        state_next.rsp.rdata = {16'h0000, rv};
      end else if (rd_idx[0]) begin
        state_next.rsp.rdata = {24'h000000, rv[15:8]};
      end else begin
        state_next.rsp.rdata = {24'h000000, rv[7:0]};
      end
    end
    if (state_reg.rsp.rvalid && I_AXI_REQ.rready) begin
      state_next.rsp.rvalid = 1'b0;
      state_next.rsp.arready = 1'b1;
    end

    // Byte lanes of the pending write
    if (bus16) begin
      wd = state_reg.wdata[15:0];
      wm = {{8{state_reg.wstrb[1]}}, {8{state_reg.wstrb[0]}}};
    end else begin
      wd = {2{state_reg.wdata[7:0]}};
      wm = wr_idx[0] ? {{8{state_reg.wstrb[0]}}, 8'h00} : {8'h00, {8{state_reg.wstrb[0]}}};
    end
    if (!wr_do || !wr_map) begin
      wm = 16'h0000;
    end
    // Global control register, reserved bits kept but unused
    if (wr_idx[10:9] == 2'h0 && wr_even == OFS_GL_CTRL) begin
      state_next.gl_ctrl = (state_reg.gl_ctrl & ~wm) | (wd & wm);
    end

    // Counter snapshot sequence
    state_next.snap_prev = state_reg.gl_ctrl[GC_SNAP_BIT];
    state_next.zero_n = 1'b1;
    case (state_reg.snap_st)
      SNAP_IDLE: begin
        if (snap_go) begin
          state_next.snap_st = SNAP_LOAD;
          state_next.done = 1'b0;
        end
      end
      SNAP_LOAD: begin
        state_next.snap_st = SNAP_IDLE;
        state_next.done = 1'b1;
        state_next.zero_n = 1'b0;
      end
      default: begin
        state_next.snap_st = SNAP_IDLE;
      end
    endcase

    // Per-port status, counters and configuration
    for (int i = 0; i < NUM_PORTS; i++) begin
      rise = I_EVENT[i] & ~state_reg.ports[i].ev_prev;
      fall = ~I_EVENT[i] & state_reg.ports[i].ev_prev;
      set = rise;
      set[CHG_EV_BIT] = rise[CHG_EV_BIT] | fall[CHG_EV_BIT];
      if (state_reg.ports[i].mode_app) begin
        set = set & ~RSV_MASK;
      end
      state_next.ports[i].ev_prev = I_EVENT[i];
      // Mode takes effect only while the data path runs
      if (state_reg.ports[i].ctrl[PC_MODE_BIT] != state_reg.ports[i].mode_app) begin
        state_next.ports[i].mode_chg = 1'b1;
        if (I_DATAPATH_RESET_N) begin
          state_next.ports[i].mode_app = state_reg.ports[i].ctrl[PC_MODE_BIT];
        end
      end
      // Register writes aimed at this port
      hit = (32'(wr_idx[10:9]) == 32'(i)) && (wr_even >= PORT_FIRST);
      clr = '0;
      if (hit && wr_even == OFS_P_CTRL) begin
        state_next.ports[i].ctrl = (state_reg.ports[i].ctrl & ~wm) | (wd & wm);
      end
      if (hit && wr_even == OFS_P_IE) begin
        state_next.ports[i].ie = (state_reg.ports[i].ie & ~wm) | (wd & wm);
      end
      if (hit && lcm && wr_even == OFS_P_LATCH) begin
        clr = wd[EV_W-1:0] & wm[EV_W-1:0];
      end
      // Reading the latched register clears it in clear-on-read mode, in byte mode only through its low byte
      if (rd_take && rd_map && !lcm && 32'(rd_idx[10:9]) == 32'(i) && rd_even == OFS_P_LATCH) begin
        if (bus16 || !rd_idx[0]) begin
          clr = '1;
        end
      end
      // A new event beats a clear in the same cycle
      state_next.ports[i].latch = (state_reg.ports[i].latch & ~clr) | set;
      // Counting and snapshot, losing no event in the snapshot load cycle
      inc = I_COUNT_EVENT[i] && !state_reg.ports[i].mode_app;
      if (state_reg.snap_st == SNAP_LOAD) begin
        state_next.ports[i].cnt_reg = state_reg.ports[i].cnt;
        state_next.ports[i].cnt = inc ? 16'h0001 : 16'h0000;
      end else if (inc && state_reg.ports[i].cnt != CNT_MAX) begin
        state_next.ports[i].cnt = state_reg.ports[i].cnt + 16'h0001;
      end
      // Data path reset after a mode change wipes the history
      if (!I_DATAPATH_RESET_N && state_reg.ports[i].mode_chg) begin
        state_next.ports[i].latch = '0;
        state_next.ports[i].cnt = 16'h0000;
        state_next.ports[i].cnt_reg = 16'h0000;
        state_next.ports[i].mode_chg = 1'b0;
      end
      if (32'(i) >= PORT_COUNT) begin
        state_next.ports[i] = '0;
      end
      any_int = any_int | (|(state_reg.ports[i].latch & state_reg.ports[i].ie[EV_W-1:0]));
    end
    state_next.int_n = !any_int;
  end

  // Reset release through two flip-flops
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Whole state register, defaults restored on global reset
  always_ff @(posedge I_CLOCK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= '0;
      state_reg.rsp.awready <= 1'b1;
      state_reg.rsp.wready <= 1'b1;
      state_reg.rsp.arready <= 1'b1;
      state_reg.gl_ctrl <= GL_CTRL_RST;
      state_reg.snap_st <= SNAP_IDLE;
      state_reg.done <= 1'b1;
      state_reg.zero_n <= 1'b1;
      state_reg.int_n <= 1'b1;
      for (int i = 0; i < NUM_PORTS; i++) begin
        state_reg.ports[i].ctrl <= P_CTRL_RST;
        state_reg.ports[i].ie <= P_IE_RST;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign O_AXI_RSP = state_reg.rsp;
  assign O_COUNTER_SNAPSHOT_DONE = state_reg.done;
  assign O_ZERO_COUNT_N = state_reg.zero_n;
  assign O_INT_N = state_reg.int_n;

  // Checks on port 0, the snapshot outputs and the bus

  property p_cnt_saturate;
    (state_reg.ports[0].cnt == CNT_MAX) && (state_reg.snap_st == SNAP_IDLE) && I_DATAPATH_RESET_N
      |=> state_reg.ports[0].cnt == CNT_MAX;
  endproperty
  a_cnt_saturate: assert property (p_cnt_saturate)
    else $error("counter left its maximum");

  property p_snap_seq;
    snap_go |=> !O_COUNTER_SNAPSHOT_DONE && O_ZERO_COUNT_N
      ##1 (O_COUNTER_SNAPSHOT_DONE && !O_ZERO_COUNT_N) ##1 O_ZERO_COUNT_N;
  endproperty
  a_snap_seq: assert property (p_snap_seq)
    else $error("snapshot sequence wrong");

  property p_snap_copy;
    (state_reg.snap_st == SNAP_LOAD) && !(state_reg.ports[0].mode_chg && !I_DATAPATH_RESET_N)
      |=> state_reg.ports[0].cnt_reg == $past(state_reg.ports[0].cnt);
  endproperty
  a_snap_copy: assert property (p_snap_copy)
    else $error("snapshot did not copy the count");

  property p_latch_rise;
    I_EVENT[0][0] && !state_reg.ports[0].ev_prev[0] && I_DATAPATH_RESET_N
      |=> state_reg.ports[0].latch[0];
  endproperty
  a_latch_rise: assert property (p_latch_rise)
    else $error("latched bit missed an event");

  property p_latch_quiet;
    !state_reg.ports[0].latch[0] && !(I_EVENT[0][0] && !state_reg.ports[0].ev_prev[0])
      |=> !state_reg.ports[0].latch[0];
  endproperty
  a_latch_quiet: assert property (p_latch_quiet)
    else $error("latched bit set without a new event");

  property p_change_fall;
    !I_EVENT[0][CHG_EV_BIT] && state_reg.ports[0].ev_prev[CHG_EV_BIT] && !state_reg.ports[0].mode_app
      && I_DATAPATH_RESET_N |=> state_reg.ports[0].latch[CHG_EV_BIT];
  endproperty
  a_change_fall: assert property (p_change_fall)
    else $error("change bit missed the event end");

  property p_reserved_latch;
    state_reg.ports[0].mode_app && !state_reg.ports[0].latch[CHG_EV_BIT]
      |=> !state_reg.ports[0].latch[CHG_EV_BIT];
  endproperty
  a_reserved_latch: assert property (p_reserved_latch)
    else $error("reserved latched bit was set");

  property p_unmapped;
    rd_take && !rd_map |=> O_AXI_RSP.rvalid && (O_AXI_RSP.rresp == RESP_DECERR) && (O_AXI_RSP.rdata == 32'h00000000);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unassigned space answered as mapped");

  property p_dp_clear;
    !I_DATAPATH_RESET_N && state_reg.ports[0].mode_chg
      |=> (state_reg.ports[0].cnt == 16'h0000) && (state_reg.ports[0].cnt_reg == 16'h0000)
          && (state_reg.ports[0].latch == '0);
  endproperty
  a_dp_clear: assert property (p_dp_clear)
    else $error("data path reset did not clear history");

  property p_int;
    (|(state_reg.ports[0].latch & state_reg.ports[0].ie[EV_W-1:0])) |=> !O_INT_N;
  endproperty
  a_int: assert property (p_int)
    else $error("enabled latched bit gave no interrupt");
endmodule // rac_regs

//--- rac_pkg.sv
// Constants, carrier types and state layout of the register access block
package rac_pkg;
  localparam int NUM_PORTS = 4;
  localparam int EV_W = 4;
  localparam int AXI_AW = 13;
  // Offsets within a 200h region, as register indices
  localparam logic [8:0] OFS_GL_ID = 9'h000;
  localparam logic [8:0] OFS_GL_CTRL = 9'h002;
  localparam logic [8:0] OFS_GL_STAT = 9'h014;
  localparam logic [8:0] GL_LAST = 9'h01F;
  localparam logic [8:0] GL_UNUSED_LAST = 9'h02F;
  localparam logic [8:0] PORT_FIRST = 9'h040;
  localparam logic [8:0] OFS_P_CTRL = 9'h040;
  localparam logic [8:0] OFS_P_STAT = 9'h052;
  localparam logic [8:0] OFS_P_LATCH = 9'h054;
  localparam logic [8:0] OFS_P_IE = 9'h056;
  localparam logic [8:0] OFS_BERT_FIRST = 9'h060;
  localparam logic [8:0] OFS_ENC_FIRST = 9'h08C;
  localparam logic [8:0] OFS_DEC_FIRST = 9'h090;
  localparam logic [8:0] OFS_P_CNT = 9'h09C;
  localparam logic [8:0] OFS_HDLC_TX_FIRST = 9'h0A0;
  localparam logic [8:0] OFS_HDLC_RX_FIRST = 9'h0B0;
  // Field positions
  localparam int GC_LCM_BIT = 2;
  localparam int GC_SNAP_BIT = 3;
  localparam int GC_BUS16_BIT = 4;
  localparam int PC_MODE_BIT = 0;
  localparam int CHG_EV_BIT = 3;
  localparam logic [EV_W-1:0] RSV_MASK = 4'h8;
  // Reset values and limits
  localparam logic [15:0] GL_CTRL_RST = 16'h0010;
  localparam logic [15:0] P_CTRL_RST = 16'h0000;
  localparam logic [15:0] P_IE_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic [AXI_AW-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [AXI_AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } rac_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } rac_axi_rsp_t;

  typedef logic [EV_W-1:0] rac_ev_t;

  typedef enum logic [1:0] {
    SNAP_IDLE = 2'b01,
    SNAP_LOAD = 2'b10
  } rac_snap_e;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] ie;
    logic [EV_W-1:0] latch;
    logic [EV_W-1:0] ev_prev;
    logic [15:0] cnt;
    logic [15:0] cnt_reg;
    logic mode_app;
    logic mode_chg;
  } rac_port_t;

  typedef struct packed {
    rac_axi_rsp_t rsp;
    logic aw_have;
    logic w_have;
    logic [10:0] w_idx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [15:0] gl_ctrl;
    logic snap_prev;
    rac_snap_e snap_st;
    logic done;
    logic zero_n;
    logic int_n;
    rac_port_t [NUM_PORTS-1:0] ports;
  } rac_state_t;
endpackage

//--- rac_host.sv
// Host-side AXI4-Lite master model for the register bus
`timescale 1ns/1ps
module rac_host (
  // Clock
  input wire logic i_clk,
  // Register bus
  input wire rac_pkg::rac_axi_rsp_t i_rsp,
  output rac_pkg::rac_axi_req_t o_req
);
  import rac_pkg::*;

  // Bus idle until the first task call
  initial o_req = '0;

  // One write: address and data offered together, each dropped once taken
  task automatic wr(input logic [10:0] idx, input logic [15:0] d, input logic [3:0] s);
    o_req.awaddr <= {idx, 2'h0};
    o_req.wdata <= {16'h0000, d};
    o_req.wstrb <= s;
    o_req.awvalid <= 1'h1;
    o_req.wvalid <= 1'h1;
    o_req.bready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (o_req.awvalid && i_rsp.awready) o_req.awvalid <= 1'h0;
      if (o_req.wvalid && i_rsp.wready) o_req.wvalid <= 1'h0;
    end while (!(i_rsp.bvalid && o_req.bready));
    o_req.bready <= 1'h0;
    // Let an edge pass so a following call never re-raises bready in the same step
    @(posedge i_clk);
  endtask

  // One read: ready held until the answer is seen
  task automatic rd(input logic [10:0] idx);
    o_req.araddr <= {idx, 2'h0};
    o_req.arvalid <= 1'h1;
    o_req.rready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (o_req.arvalid && i_rsp.arready) o_req.arvalid <= 1'h0;
    end while (!(i_rsp.rvalid && o_req.rready));
    o_req.rready <= 1'h0;
    // Let an edge pass so a following call never re-raises rready in the same step
    @(posedge i_clk);
  endtask
endmodule // rac_host

//--- register_access_conventions_tb.sv
// Self-checking bench for the register access block
`timescale 1ns/1ps
module register_access_conventions_tb;
  import rac_pkg::*;
  localparam logic [15:0] ID_V = 16'h3C7E; // Identity value, arbitrary
  logic clk;
  logic rst_n;
  logic dp_n;
  rac_axi_req_t req;
  rac_axi_rsp_t rsp;
  rac_ev_t [NUM_PORTS-1:0] ev;
  logic [NUM_PORTS-1:0] cnt_ev;
  logic done;
  logic zero_n;
  logic int_n;
  int err_count;
  int checked;
  int done_lows;
  logic [15:0] lf;
  logic [17:0] rq[$];
  logic [1:0] bq[$];
  // Unassigned, absent-port and mapped-but-empty places
  logic [10:0] map_idx [6] = '{11'h020, 11'h640, 11'h7FF, 11'h062, 11'h030, 11'h200};
  logic [1:0] map_rsp [6] = '{RESP_DECERR, RESP_DECERR, RESP_DECERR, RESP_OKAY, RESP_OKAY, RESP_OKAY};

  rac_regs #(.PORT_COUNT(3), .ID_VALUE(ID_V)) rac_regs_inst (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_AXI_REQ(req), .O_AXI_RSP(rsp), .I_DATAPATH_RESET_N(dp_n),
    .I_EVENT(ev), .I_COUNT_EVENT(cnt_ev), .O_COUNTER_SNAPSHOT_DONE(done), .O_ZERO_COUNT_N(zero_n),
    .O_INT_N(int_n));
  rac_host rac_host_inst (.i_clk(clk), .i_rsp(rsp), .o_req(req));

  // 25 MHz clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // Comparison helpers, one per kind of result
  task automatic cmp_any(input string w, input logic [17:0] e, input logic [17:0] s);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic cmp_rd(input logic [17:0] e, input logic [17:0] s);
    cmp_any("read", e, s);
  endtask
  task automatic cmp_b(input logic [1:0] e, input logic [1:0] s);
    cmp_any("bresp", {16'h0000, e}, {16'h0000, s});
  endtask
  task automatic cmp_f(input string w, input logic e, input logic s);
    cmp_any(w, {17'h00000, e}, {17'h00000, s});
  endtask

  // Match each bus answer against the oldest note; count cycles with done low
  always @(posedge clk) begin
    if (rsp.rvalid && req.rready) begin
      if (rq.size() > 0) begin
        cmp_rd(rq.pop_front(), {rsp.rresp, rsp.rdata[15:0]});
      end else begin
        err_count++;
        $display("BAD read expected none seen %h", {rsp.rresp, rsp.rdata[15:0]});
      end
    end
    if (rsp.bvalid && req.bready) begin
      if (bq.size() > 0) begin
        cmp_b(bq.pop_front(), rsp.bresp);
      end else begin
        err_count++;
        $display("BAD bresp expected none seen %h", rsp.bresp);
      end
    end
    if (done === 1'h0) done_lows++;
  end

  // Bus tasks that note the expected answer first
  task automatic rd(input logic [10:0] a, input logic [1:0] r, input logic [15:0] d);
    rq.push_back({r, d});
    rac_host_inst.rd(a);
  endtask
  task automatic wr(input logic [10:0] a, input logic [15:0] d, input logic [3:0] s, input logic [1:0] r);
    bq.push_back(r);
    rac_host_inst.wr(a, d, s);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic endtest(input string n);
    $display("test %s finished, %0d mismatches so far", n, err_count);
  endtask
  task automatic int_is(input logic e);
    @(negedge clk);
    cmp_f("interrupt", e, int_n);
    @(posedge clk);
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Counter snapshot: strobe 0 then 1, then watch done and zero indication
  task automatic snap();
    int i;
    int n;
    n = done_lows;
    wr(11'h002, 16'h0010, 4'h3, RESP_OKAY);
    wr(11'h002, 16'h0018, 4'h3, RESP_OKAY);
    for (i = 0; i < 8 && zero_n !== 1'h0; i++) @(negedge clk);
    cmp_f("zero count", 1'h0, zero_n);
    cmp_f("done", 1'h1, done);
    @(negedge clk);
    cmp_f("zero count", 1'h1, zero_n);
    cmp_any("done low cycles", 18'(n + 1), 18'(done_lows));
    @(posedge clk);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'h0;
    dp_n = 1'h1;
    ev = '0;
    cnt_ev = '0;
    err_count = 0;
    checked = 0;
    done_lows = 0;
    lf = 16'hE23F;
    cyc(5);
    rst_n <= 1'h1;
    cyc(4);
    rd(11'h000, RESP_OKAY, ID_V);
    rd(11'h002, RESP_OKAY, GL_CTRL_RST);
    rd(11'h056, RESP_OKAY, P_IE_RST);
    rd(11'h014, RESP_OKAY, 16'h0001);
    endtest("reset");
    foreach (map_idx[i]) begin
      wr(map_idx[i], 16'hFFFF, 4'h3, map_rsp[i]);
      rd(map_idx[i], map_rsp[i], 16'h0000);
    end
    repeat (4) begin
      lf = lfsr(lf);
      wr(11'h240, lf, 4'h3, RESP_OKAY);
      rd(11'h240, RESP_OKAY, lf);
      wr(11'h256, ~lf, 4'h3, RESP_OKAY);
      rd(11'h256, RESP_OKAY, ~lf);
    end
    endtest("map");
    wr(11'h056, 16'h0001, 4'h3, RESP_OKAY);
    ev[0] <= 4'h1;
    cyc(3);
    int_is(1'h0);
    rd(11'h054, RESP_OKAY, 16'h0001);
    rd(11'h054, RESP_OKAY, 16'h0000);
    cyc(2);
    int_is(1'h1);
    ev[0] <= 4'h0;
    cyc(2);
    ev[0] <= 4'h1;
    cyc(3);
    rd(11'h054, RESP_OKAY, 16'h0001);
    ev[0] <= 4'h9;
    cyc(3);
    rd(11'h054, RESP_OKAY, 16'h0008);
    ev[0] <= 4'h1;
    cyc(3);
    rd(11'h054, RESP_OKAY, 16'h0008);
    endtest("latch");
    wr(11'h002, 16'h0014, 4'h3, RESP_OKAY);
    ev[0] <= 4'h0;
    cyc(2);
    ev[0] <= 4'h3;
    cyc(3);
    rd(11'h054, RESP_OKAY, 16'h0003);
    rd(11'h054, RESP_OKAY, 16'h0003);
    wr(11'h054, 16'h0001, 4'h3, RESP_OKAY);
    rd(11'h054, RESP_OKAY, 16'h0002);
    wr(11'h054, 16'h0002, 4'h3, RESP_OKAY);
    endtest("clear on write");
    wr(11'h002, 16'h0000, 4'h3, RESP_OKAY);
    ev[0] <= 4'h0;
    cyc(2);
    ev[0] <= 4'h1;
    cyc(3);
    rd(11'h055, RESP_OKAY, 16'h0000);
    rd(11'h054, RESP_OKAY, 16'h0001);
    rd(11'h054, RESP_OKAY, 16'h0000);
    wr(11'h041, 16'h00AB, 4'h1, RESP_OKAY);
    rd(11'h041, RESP_OKAY, 16'h00AB);
    rd(11'h040, RESP_OKAY, 16'h0000);
    wr(11'h002, 16'h0010, 4'h1, RESP_OKAY);
    rd(11'h002, RESP_OKAY, 16'h0010);
    endtest("byte mode");
    cnt_ev[0] <= 1'h1;
    cyc(65600);
    cnt_ev[0] <= 1'h0;
    cyc(2);
    snap();
    rd(11'h09C, RESP_OKAY, CNT_MAX);
    snap();
    rd(11'h09C, RESP_OKAY, 16'h0000);
    endtest("counter");
    ev[0] <= 4'h0;
    cyc(2);
    ev[0] <= 4'h1;
    cyc(3);
    wr(11'h040, 16'h0001, 4'h3, RESP_OKAY);
    dp_n <= 1'h0;
    cyc(3);
    rd(11'h054, RESP_OKAY, 16'h0000);
    wr(11'h040, 16'h00A1, 4'h3, RESP_OKAY);
    rd(11'h040, RESP_OKAY, 16'h00A1);
    dp_n <= 1'h1;
    cyc(2);
    ev[0] <= 4'hF;
    cyc(3);
    rd(11'h052, RESP_OKAY, 16'h0007);
    rd(11'h054, RESP_OKAY, 16'h0006);
    endtest("mode");
    cyc(4);
    tally_and_finish();
  end

  // Cut a hung run short
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
endmodule // register_access_conventions_tb
